//--- bus_masters.sv
// Behavioural processor and debug bus masters facing the controller.
`timescale 1ns/1ps
`default_nettype none
module bus_masters (
	// Clock.
	input wire logic clk,
	// Processor master.
	output logic cpu_req,
	output logic [15:0] cpu_addr,
	input wire logic cpu_grant,
	input wire logic sys_reset_req,
	// Debug master.
	output logic dbg_req,
	output logic [15:0] dbg_addr,
	output logic [3:0] dbg_page,
	input wire logic dbg_grant,
	input wire logic dbg_denied,
	// Shared side.
	input wire logic [17:0] glob_addr
);
	// Idle masters start released.
	initial begin
		cpu_req = 1'b0;
		cpu_addr = 16'hffff;
		dbg_req = 1'b0;
		dbg_addr = 16'hffff;
		dbg_page = 4'hf;
	end
	task automatic access(input logic dbg, input logic [15:0] a,
		input logic [3:0] pg, output logic [17:0] ga, output logic fl,
		output logic ok);
		ok = 1'b0;
		ga = '0;
		fl = 1'b0;
		@(posedge clk);
		if (dbg) begin
			dbg_req <= 1'b1;
			dbg_addr <= a;
			dbg_page <= pg;
		end else begin
			cpu_req <= 1'b1;
			cpu_addr <= a;
		end
		for (int i = 0; i < 20 && !ok; i++) begin
			@(posedge clk);
			#1;
			ok = dbg ? dbg_grant === 1'b1 : cpu_grant === 1'b1;
		end
		ga = glob_addr;
		fl = dbg ? dbg_denied : sys_reset_req;
		@(posedge clk);
		// Released lines show the inverse so stale values never match.
		if (dbg) begin
			dbg_req <= 1'b0;
			dbg_addr <= ~a;
			dbg_page <= ~pg;
		end else begin
			cpu_req <= 1'b0;
			cpu_addr <= ~a;
		end
	endtask
endmodule // bus_masters
`default_nettype wire

//--- master_arb.sv
// Two-master bus arbiter; the debug master has priority when idle.
`timescale 1ns/1ps
`default_nettype none
module master_arb (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Requests.
	input wire logic cpu_req,
	input wire logic dbg_req,
	// Grants.
	output var mode_map_pkg::grant_e grant
);
	import mode_map_pkg::*;

	grant_e grant_ff;
	grant_e nxt_grant;

	// one master: a grant holds until its owner drops the request.
	always_comb begin
		nxt_grant = grant_ff;
		unique case (grant_ff)
			GNT_NONE: begin
				if (dbg_req) begin
					nxt_grant = GNT_DBG;
				end else if (cpu_req) begin
					nxt_grant = GNT_CPU;
				end
			end
			GNT_CPU: begin
				if (!cpu_req) begin
					nxt_grant = GNT_NONE;
				end
			end
			GNT_DBG: begin
				if (!dbg_req) begin
					nxt_grant = GNT_NONE;
				end
			end
		endcase
	end

	// Grant state register.
	always_ff @(posedge clk) begin
		if (srst) begin
			grant_ff <= GNT_NONE;
		end else begin
			grant_ff <= nxt_grant;
		end
	end

	assign grant = grant_ff;
endmodule // master_arb
`default_nettype wire

//--- mode_map_checker.sv
// Port-level assertions for the mode and memory map controller.
`timescale 1ns/1ps
`default_nettype none
module mode_map_checker (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// APB side.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Mode and masters.
	input wire logic reset_pin_n,
	input wire logic mode_select_pin,
	input wire logic secured,
	input wire logic normal_single_chip,
	input wire logic dbg_enter,
	input wire logic cpu_grant,
	input wire logic dbg_grant,
	input wire logic [3:0] program_page_bits
);
	localparam logic [11:0] MODE_ADDR = 12'h02c;
	// A mode write commits at the edge where pready is sampled high.
	logic mode_wr;
	assign mode_wr = psel && penable && pready && pwrite &&
		(paddr == MODE_ADDR);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_ready_one_wait: assert property (
		psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not one cycle after access start");
	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("pready held past one cycle");
	a_err_with_ready: assert property (
		pslverr |-> pready)
		else $error("pslverr without pready");
	a_pin_follows: assert property (
		!reset_pin_n |=> normal_single_chip == $past(mode_select_pin))
		else $error("mode not following pin in reset");
	a_release_load: assert property (
		reset_pin_n && !$past(reset_pin_n) |=>
		normal_single_chip == $past(mode_select_pin))
		else $error("pin not loaded at reset release");
	a_debug_entry: assert property (
		reset_pin_n && !$past(reset_pin_n) && !mode_select_pin |->
		##[1:2] dbg_enter)
		else $error("no debug entry after special reset");
	// A reset release in the same cycle may legally reload the mode bit.
	a_secure_block: assert property (
		mode_wr && secured && reset_pin_n && $past(reset_pin_n) |=>
		$stable(normal_single_chip))
		else $error("mode changed while secured");
	a_no_downgrade: assert property (
		mode_wr && normal_single_chip && !pwdata[7] && reset_pin_n &&
		$past(reset_pin_n) |=> normal_single_chip)
		else $error("normal to special transition taken");
	a_one_grant: assert property (
		!(cpu_grant && dbg_grant))
		else $error("both masters granted");
	a_page_reset: assert property (
		$fell(srst) |-> program_page_bits == 4'he)
		else $error("page register reset value wrong");
endmodule // mode_map_checker
bind mode_map_ctrl mode_map_checker mode_map_checker_i (.clk, .srst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .reset_pin_n,
	.mode_select_pin, .secured, .normal_single_chip, .dbg_enter, .cpu_grant,
	.dbg_grant, .program_page_bits);
`default_nettype wire

//--- mode_map_ctrl.sv
// Operating mode, page registers and master arbitration with map control.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mode_map_ctrl #(
	parameter logic [mode_map_pkg::PAGE_W-1:0] FIRST_PAGE =
		mode_map_pkg::FLASH_FIRST_PAGE
) (
	// Clock and synchronous reset.
	input wire logic clk,
	input wire logic srst,
	// APB register slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mode_map_pkg::APB_AW-1:0] paddr,
	input wire logic [mode_map_pkg::APB_DW-1:0] pwdata,
	output logic [mode_map_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Mode pins and security state.
	input wire logic reset_pin_n,
	input wire logic mode_select_pin,
	input wire logic secured,
	output logic normal_single_chip,
	output logic dbg_enter,
	// Processor master.
	input wire logic cpu_req,
	input wire logic [mode_map_pkg::LADDR_W-1:0] cpu_addr,
	output logic cpu_grant,
	// Background debug master.
	input wire logic dbg_req,
	input wire logic [mode_map_pkg::LADDR_W-1:0] dbg_addr,
	input wire logic [mode_map_pkg::PAGE_W-1:0] dbg_page,
	output logic dbg_grant,
	output logic dbg_denied,
	// Shared resource side.
	output logic [mode_map_pkg::GADDR_W-1:0] glob_addr,
	output logic glob_valid,
	output logic sys_reset_req,
	output logic [mode_map_pkg::PAGE_W-1:0] program_page_bits,
	output logic [mode_map_pkg::DIRECT_W-1:0] direct_page_bits
);
	import mode_map_pkg::*;

	// APB state.
	logic pready_ff;
	logic pslverr_ff;
	logic [APB_DW-1:0] prdata_ff;
	logic [APB_DW-1:0] rd_data;
	logic hit;
	logic sel_mode;
	logic sel_direct;
	logic sel_page;
	logic acc_first;
	logic wr_fire;

	// Mode state.
	logic mode_ff;
	logic reset_pin_q_ff;
	logic mode_lock_ff;
	logic dbg_enter_ff;
	logic pin_release;
	logic mode_wr_try;
	logic mode_new;
	logic mode_allowed;
	logic mode_gate;

	// Page registers.
	logic [PAGE_W-1:0] page_ff;
	logic [DIRECT_W-1:0] direct_ff;
	logic direct_once_ff;

	// Arbitration and translation.
	grant_e grant;
	logic [GADDR_W-1:0] cpu_gaddr;
	logic [GADDR_W-1:0] dbg_gaddr;
	logic cpu_unimpl;
	logic dbg_unimpl;
	logic cpu_in_flash;
	logic dbg_in_flash;
	logic cpu_grant_ff;
	logic dbg_grant_ff;
	logic [GADDR_W-1:0] glob_addr_ff;
	logic glob_valid_ff;
	logic dbg_denied_ff;
	logic sys_reset_ff;

	// Address decode; misaligned byte offsets never hit a register.
	assign sel_mode = (paddr[APB_AW-1:2] == MODE_IDX);
	assign sel_direct = (paddr[APB_AW-1:2] == DIRECT_IDX);
	assign sel_page = (paddr[APB_AW-1:2] == PAGE_IDX);
	assign hit = (paddr[1:0] == WORD_ALIGNED) &&
		(sel_mode || sel_direct || sel_page);
	assign acc_first = psel && penable && !pready_ff;
	// A write commits only at the edge where pready is seen high.
	assign wr_fire = psel && penable && pready_ff && pwrite && hit;

	// Read mux; reserved bits read as zero.
	// read anytime
	always_comb begin
		rd_data = '0;
		if (sel_mode) begin
			rd_data[MODE_BIT] = mode_ff;
		end else if (sel_direct) begin
			rd_data[DIRECT_W-1:0] = direct_ff;
		end else if (sel_page) begin
			rd_data[PAGE_W-1:0] = page_ff;
		end
	end

	// One wait state: pready rises in the second access cycle, then drops.
	always_ff @(posedge clk) begin
		if (srst) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= acc_first;
		end
	end

	// Read data and error are captured with pready and held alongside it.
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end else if (acc_first) begin
			prdata_ff <= (hit && !pwrite) ? rd_data : '0;
			pslverr_ff <= !hit;
		end else begin
			pslverr_ff <= 1'b0;
		end
	end

	// Release of the external reset is seen as low followed by high.
	always_ff @(posedge clk) begin
		if (srst) begin
			reset_pin_q_ff <= 1'b0;
		end else begin
			reset_pin_q_ff <= reset_pin_n;
		end
	end
	assign pin_release = reset_pin_n && !reset_pin_q_ff;

	// Mode write qualification.
	// secured blocks
	assign mode_wr_try = wr_fire && sel_mode && !secured;
	assign mode_new = pwdata[MODE_BIT];
	assign mode_allowed = (mode_new == mode_ff) ||
		((mode_ff == MODE_SPECIAL) && (mode_new == MODE_NORMAL));
	assign mode_gate = !mode_lock_ff || (mode_ff == MODE_SPECIAL);

	// The mode bit tracks the pin during external reset and at its release.
	// pin overrides bit
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_ff <= MODE_SRST;
		end else if (!reset_pin_n || pin_release) begin
			mode_ff <= mode_select_pin;
		end else if (mode_wr_try && mode_gate && mode_allowed) begin
			mode_ff <= mode_new;
		end
	end

	// A rejected transition locks out later writes until the next reset.
	// lock on reject
	always_ff @(posedge clk) begin
		if (srst || !reset_pin_n) begin
			mode_lock_ff <= 1'b0;
		end else if (mode_wr_try && mode_gate && !mode_allowed) begin
			mode_lock_ff <= 1'b1;
		end
	end

	// Active debug is requested once per reset release in special mode.
	// debug after reset
	always_ff @(posedge clk) begin
		if (srst) begin
			dbg_enter_ff <= 1'b0;
		end else begin
			dbg_enter_ff <= pin_release && (mode_select_pin == MODE_SPECIAL);
		end
	end

	// Program page index; upper bits are not stored.
	// page reset value
	always_ff @(posedge clk) begin
		if (srst) begin
			page_ff <= PAGE_RST;
		end else if (wr_fire && sel_page) begin
			page_ff <= pwdata[PAGE_W-1:0];
		end
	end

	// Direct page register; normal mode allows one write per srst (not per pin reset) so that
	// stray code cannot move the direct page once it is set up.
	// write once normal
	always_ff @(posedge clk) begin
		if (srst) begin
			direct_ff <= DIRECT_RST;
			direct_once_ff <= 1'b0;
		end else if (wr_fire && sel_direct &&
			((mode_ff == MODE_SPECIAL) || !direct_once_ff)) begin
			direct_ff <= pwdata[DIRECT_W-1:0];
			direct_once_ff <= (mode_ff == MODE_NORMAL);
		end
	end

	master_arb u_arb (
		.clk(clk),
		.srst(srst),
		.cpu_req(cpu_req),
		.dbg_req(dbg_req),
		.grant(grant)
	);

	page_map #(.FIRST_PAGE(FIRST_PAGE)) u_cpu_map (
		.laddr(cpu_addr),
		.page(page_ff),
		.gaddr(cpu_gaddr),
		.unimpl(cpu_unimpl),
		.in_flash(cpu_in_flash)
	);

	// The debug master pages through its own page index.
	page_map #(.FIRST_PAGE(FIRST_PAGE)) u_dbg_map (
		.laddr(dbg_addr),
		.page(dbg_page),
		.gaddr(dbg_gaddr),
		.unimpl(dbg_unimpl),
		.in_flash(dbg_in_flash)
	);

	// Grant outputs are registered copies of the arbiter state.
	always_ff @(posedge clk) begin
		if (srst) begin
			cpu_grant_ff <= 1'b0;
			dbg_grant_ff <= 1'b0;
		end else begin
			cpu_grant_ff <= (grant == GNT_CPU);
			dbg_grant_ff <= (grant == GNT_DBG);
		end
	end

	// The granted master's global address drives the shared resources.
	// secured blocks flash
	always_ff @(posedge clk) begin
		if (srst) begin
			glob_addr_ff <= '0;
			glob_valid_ff <= 1'b0;
			dbg_denied_ff <= 1'b0;
		end else begin
			glob_valid_ff <= 1'b0;
			dbg_denied_ff <= 1'b0;
			if (grant == GNT_CPU && cpu_req) begin
				glob_addr_ff <= cpu_gaddr;
				glob_valid_ff <= !cpu_unimpl;
			end else if (grant == GNT_DBG && dbg_req) begin
				glob_addr_ff <= dbg_gaddr;
				if (secured && dbg_in_flash) begin
					dbg_denied_ff <= 1'b1;
				end else begin
					glob_valid_ff <= !dbg_unimpl;
				end
			end
		end
	end

	// Both implemented modes are single-chip, so the check always applies;
	// debug accesses to holes are simply not forwarded.
	// reset on hole
	always_ff @(posedge clk) begin
		if (srst) begin
			sys_reset_ff <= 1'b0;
		end else begin
			sys_reset_ff <= (grant == GNT_CPU) && cpu_req && cpu_unimpl &&
				cpu_in_flash;
		end
	end

	// Output assignments, each straight from a register.
	// bit sets mode
	assign normal_single_chip = mode_ff;
	assign dbg_enter = dbg_enter_ff;
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign cpu_grant = cpu_grant_ff;
	assign dbg_grant = dbg_grant_ff;
	assign dbg_denied = dbg_denied_ff;
	assign glob_addr = glob_addr_ff;
	assign glob_valid = glob_valid_ff;
	assign sys_reset_req = sys_reset_ff;
	assign program_page_bits = page_ff;
	assign direct_page_bits = direct_ff;
endmodule // mode_map_ctrl
`default_nettype wire

//--- mode_map_ctrl_tb.sv
// Self-checking testbench for the mode and memory map controller.
`timescale 1ns/1ps
`default_nettype none
module mode_map_ctrl_tb;
	import mode_map_pkg::*;
	localparam logic [11:0] A_MODE = {MODE_IDX, WORD_ALIGNED};
	localparam logic [11:0] A_DIR = {DIRECT_IDX, WORD_ALIGNED};
	localparam logic [11:0] A_PG = {PAGE_IDX, WORD_ALIGNED};
	logic clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic reset_pin_n, mode_select_pin, secured, normal_single_chip, dbg_enter;
	logic cpu_req, cpu_grant, dbg_req, dbg_grant, dbg_denied;
	logic glob_valid, sys_reset_req, er, seen;
	logic [15:0] cpu_addr, dbg_addr;
	logic [3:0] dbg_page, program_page_bits;
	logic [7:0] direct_page_bits;
	logic [17:0] glob_addr;
	int fails = 0;
	int cmp_count = 0;
	mode_map_ctrl mode_map_ctrl_i (.clk, .srst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n,
		.mode_select_pin, .secured, .normal_single_chip, .dbg_enter, .cpu_req,
		.cpu_addr, .cpu_grant, .dbg_req, .dbg_addr, .dbg_page, .dbg_grant,
		.dbg_denied, .glob_addr, .glob_valid, .sys_reset_req,
		.program_page_bits, .direct_page_bits);
	bus_masters bus_masters_i (.clk, .cpu_req, .cpu_addr, .cpu_grant,
		.sys_reset_req, .dbg_req, .dbg_addr, .dbg_page, .dbg_grant,
		.dbg_denied, .glob_addr);
	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic results();
		if (fails == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			fails++;
		end
	endtask
	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			#1;
			if (pready === 1'b1) break;
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		if (n == 20) begin
			check("pready", 1, 0);
			results();
		end
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(nm, e, rd);
		check({nm, "_err"}, 0, er);
	endtask
	// Pulse the external reset with a given strap level.
	task automatic pin_reset(input logic p);
		@(posedge clk);
		reset_pin_n <= 1'b0;
		mode_select_pin <= p;
		repeat (3) @(posedge clk);
		reset_pin_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic go(input logic dbg, input logic [15:0] a, input logic [3:0] pg,
		input logic [17:0] e, input logic ef);
		logic [17:0] ga;
		logic fl, ok;
		bus_masters_i.access(dbg, a, pg, ga, fl, ok);
		check("grant", 1, ok);
		// A master that was never granted has hit its bound.
		if (ok !== 1'b1) begin
			results();
		end
		check("gaddr", e, ga);
		check("flag", ef, fl);
		// The forwarded strobe is clear exactly when the access is refused.
		#1;
		check("gvalid", !ef, glob_valid);
	endtask
	// Main sequence.
	initial begin
		srst = 1'b1;
		{psel, penable, pwrite, secured} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		reset_pin_n = 1'b0;
		mode_select_pin = MODE_SPECIAL;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check("mode_low", MODE_SPECIAL, normal_single_chip);
		@(posedge clk);
		reset_pin_n <= 1'b1;
		seen = 1'b0;
		repeat (4) begin
			@(posedge clk);
			#1;
			seen = seen | (dbg_enter === 1'b1);
		end
		check("debug_entry", 1, seen);
		mode_select_pin <= MODE_NORMAL;
		repeat (3) @(posedge clk);
		#1;
		check("mode_kept", MODE_SPECIAL, normal_single_chip);
		rchk("mode_rd", A_MODE, 32'h0);
		rchk("page_rst", A_PG, 32'he);
		rchk("dir_rst", A_DIR, 32'h0);
		apb(1'b1, A_DIR, 32'h12);
		apb(1'b1, A_DIR, 32'h34);
		rchk("dir_ss", A_DIR, 32'h34);
		apb(1'b1, A_MODE, 32'h80);
		rchk("mode_up", A_MODE, 32'h80);
		check("mode_port", MODE_NORMAL, normal_single_chip);
		apb(1'b1, A_DIR, 32'h56);
		apb(1'b1, A_DIR, 32'h78);
		rchk("dir_normal", A_DIR, 32'h56);
		check("dir_port", 8'h56, direct_page_bits);
		apb(1'b1, A_MODE, 32'h00);
		rchk("mode_rej", A_MODE, 32'h80);
		apb(1'b1, A_MODE, 32'h00);
		rchk("mode_lock", A_MODE, 32'h80);
		apb(1'b0, 12'h030, 32'h0);
		check("unmapped", 1, er);
		pin_reset(MODE_SPECIAL);
		secured <= 1'b1;
		apb(1'b1, A_MODE, 32'h80);
		rchk("mode_sec", A_MODE, 32'h0);
		secured <= 1'b0;
		go(1'b0, 16'h0500, 4'h0, {PAGE_FIX0, 14'h0500}, 1'b0);
		go(1'b0, 16'h4010, 4'h0, {PAGE_FIX1, 14'h0010}, 1'b0);
		go(1'b0, 16'hc001, 4'h0, {PAGE_FIX3, 14'h0001}, 1'b0);
		fork
			go(1'b0, 16'h8123, 4'h0, {4'he, 14'h0123}, 1'b0);
			go(1'b1, 16'h8005, 4'h9, {4'h9, 14'h0005}, 1'b0);
		join
		apb(1'b1, A_PG, 32'h3);
		go(1'b0, 16'h8000, 4'h0, {4'h3, 14'h0000}, 1'b1);
		secured <= 1'b1;
		go(1'b1, 16'h8000, 4'h9, {4'h9, 14'h0000}, 1'b1);
		results();
	end
endmodule // mode_map_ctrl_tb
`default_nettype wire

//--- mode_map_pkg.sv
// Shared constants and types for the mode and memory map controller.
package mode_map_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [9:0] MODE_IDX = 10'h00b;
	localparam logic [9:0] DIRECT_IDX = 10'h011;
	localparam logic [9:0] PAGE_IDX = 10'h015;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	localparam logic [1:0] WORD_ALIGNED = 2'h0;
	// Field layout.
	localparam int MODE_BIT = 7;
	localparam int PAGE_W = 4;
	localparam int DIRECT_W = 8;
	// Mode encodings and reset values.
	localparam logic MODE_SPECIAL = 1'b0;
	localparam logic MODE_NORMAL = 1'b1;
	localparam logic MODE_SRST = 1'b1;
	localparam logic [PAGE_W-1:0] PAGE_RST = 4'he;
	localparam logic [DIRECT_W-1:0] DIRECT_RST = 8'h00;
	// Local and global address layout.
	localparam int LADDR_W = 16;
	localparam int GADDR_W = 18;
	localparam int OFFS_W = 14;
	localparam logic [1:0] BLK_FIX0 = 2'h0;
	localparam logic [1:0] BLK_FIX1 = 2'h1;
	localparam logic [1:0] BLK_WIN = 2'h2;
	localparam logic [1:0] BLK_FIX3 = 2'h3;
	localparam logic [PAGE_W-1:0] PAGE_FIX0 = 4'hc;
	localparam logic [PAGE_W-1:0] PAGE_FIX1 = 4'hd;
	localparam logic [PAGE_W-1:0] PAGE_FIX3 = 4'hf;
	localparam logic [PAGE_W-1:0] FLASH_FIRST_PAGE = 4'h8;
	localparam logic [LADDR_W-1:0] REG_SPACE_END = 16'h0400;
	// Arbiter states.
	typedef enum logic [1:0] {GNT_NONE, GNT_CPU, GNT_DBG} grant_e;
endpackage

//--- page_map.sv
// Local to global address translation for one bus master.
`timescale 1ns/1ps
`default_nettype none
module page_map #(
	parameter logic [mode_map_pkg::PAGE_W-1:0] FIRST_PAGE =
		mode_map_pkg::FLASH_FIRST_PAGE
) (
	// Local side.
	input wire logic [mode_map_pkg::LADDR_W-1:0] laddr,
	input wire logic [mode_map_pkg::PAGE_W-1:0] page,
	// Global side.
	output var logic [mode_map_pkg::GADDR_W-1:0] gaddr,
	output var logic unimpl,
	output var logic in_flash
);
	import mode_map_pkg::*;

	logic [PAGE_W-1:0] pg;

	// page window: only the third block is paged, the rest are fixed.
	always_comb begin
		unique case (laddr[LADDR_W-1:OFFS_W])
			BLK_FIX0: pg = PAGE_FIX0;
			BLK_FIX1: pg = PAGE_FIX1;
			BLK_WIN: pg = page;
			BLK_FIX3: pg = PAGE_FIX3;
		endcase
	end

	assign gaddr = {pg, laddr[OFFS_W-1:0]};
	// Pages below the first implemented flash page hold nothing.
	assign unimpl = (pg < FIRST_PAGE);
	// The low register space is not flash even in the fixed page.
	assign in_flash = (laddr >= REG_SPACE_END);
endmodule // page_map
`default_nettype wire
